// ==== core/serial_flash_defines.vh ====
// Constants of the serial flash bus front end.
// Assumes a 100 MHz core clock; included by its bare name.
`ifndef SERIAL_FLASH_DEFINES_VH
`define SERIAL_FLASH_DEFINES_VH

// Timing
`define CORE_CLK_MHZ 100
`define RESET_PULSE_MIN_WIDTH_NS 1000
`define RESET_PULSE_MIN_CYCLES ((`RESET_PULSE_MIN_WIDTH_NS * `CORE_CLK_MHZ + 999) / 1000)

// Opcodes
`define OP_READ3 8'h03
`define OP_READ4 8'h13
`define OP_FAST3 8'h0B
`define OP_FAST4 8'h0C
`define OP_QOUT3 8'h6B
`define OP_QOUT4 8'h6C
`define OP_QIO3 8'hEB
`define OP_QIO4 8'hEC
`define OP_QDTR3 8'hED
`define OP_QDTR4 8'hEE
`define OP_PP3 8'h02
`define OP_PP4 8'h12
`define OP_QPP3 8'h32
`define OP_QPP4 8'h34
`define OP_XQPP3 8'hC2
`define OP_XQPP4 8'h3E
`define OP_QCMD_ENTER 8'h38
`define OP_QCMD_EXIT 8'hFF
`define OP_RESET_ARM 8'h66
`define OP_RESET_GO 8'h99

// Dummy clock counts
`define DUMMY_FAST 5'h08
`define DUMMY_QOUT 5'h08
`define DUMMY_QIO 5'h06
`define DUMMY_QDTR 5'h08

// Array geometry
`define ADDR_MSB 26
`define PAGE_SHIFT 8
`define SECTOR_SHIFT 12
`define BLOCK64_SHIFT 16
`define BLOCK32_SHIFT 15

`endif

// ==== core/flash_pin_sync.v ====
// Two-flop synchroniser for a group of pins.
// Assumes the inputs are asynchronous to i_core_clk.
module flash_pin_sync #(
    parameter WIDTH = 6,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
    // Clock and reset
    input wire i_core_clk,
    input wire i_rst_n,
    // Pins
    input wire [WIDTH-1:0] i_d,
    output wire [WIDTH-1:0] o_q
);
    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_q <= INIT;
            sync_q <= INIT;
        end else begin
            meta_q <= i_d;
            sync_q <= meta_q;
        end
    end

    assign o_q = sync_q;
endmodule // flash_pin_sync

// ==== core/flash_reset_pulse_filter.v ====
// Qualifies the hardware reset pin by its low time.
// Assumes the pin is asynchronous; hold stays up while the pin stays low.
`include "serial_flash_defines.vh"
module flash_reset_pulse_filter #(
    parameter [11:0] MIN_CYCLES = `RESET_PULSE_MIN_CYCLES
) (
    // Clock and reset
    input wire i_core_clk,
    input wire i_rst_n,
    // Reset pin
    input wire i_hw_reset_n,
    output reg o_hold
);
    reg meta_q;
    reg pin_q;
    reg [11:0] cnt_q;

    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_q <= 1'b1;
            pin_q <= 1'b1;
            cnt_q <= 12'h000;
            o_hold <= 1'b0;
        end else begin
            meta_q <= i_hw_reset_n;
            pin_q <= meta_q;
            if (pin_q) begin
                cnt_q <= 12'h000;
                o_hold <= 1'b0;
            end else if (cnt_q >= MIN_CYCLES - 12'h001) begin
                o_hold <= 1'b1;
            end else begin
                cnt_q <= cnt_q + 12'h001;
            end
        end
    end
endmodule // flash_reset_pulse_filter

// ==== core/serial_flash_bus_front_end.v ====
// Bus front end of a serial NOR flash: pins in, decoded frames out.
// Assumes SCLK, CS#, IO and RESET# arrive asynchronously; SCLK well below core clock / 8.
`include "serial_flash_defines.vh"
module serial_flash_bus_front_end (
    // Clock and reset
    input wire i_core_clk,
    input wire i_rst_n,
    // Flash pins
    input wire i_sclk,
    input wire i_cs_n,
    input wire i_hw_reset_n,
    input wire [3:0] i_io,
    output reg [3:0] o_io,
    output reg [3:0] o_io_oe_n,
    // Command and address
    output reg [7:0] o_cmd,
    output reg o_cmd_valid,
    output reg [31:0] o_addr,
    output reg o_addr_valid,
    output reg [18:0] o_page_index,
    output reg [14:0] o_sector_index,
    output reg [11:0] o_block32_index,
    output reg [10:0] o_block64_index,
    // Data
    output reg [7:0] o_wr_data,
    output reg o_wr_valid,
    output reg o_rd_req,
    input wire [7:0] i_rd_data,
    // Status
    output reg o_frame_end,
    output reg o_quad_command_mode,
    output reg o_dtr_active,
    output reg o_write_protect,
    output reg o_reset_event
);
    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_OPC = 3'd1;
    localparam [2:0] ST_ADDR = 3'd2;
    localparam [2:0] ST_DUMMY = 3'd3;
    localparam [2:0] ST_DIN = 3'd4;
    localparam [2:0] ST_DOUT = 3'd5;
    localparam [2:0] ST_IGNORE = 3'd6;
    localparam [5:0] SYNC_INIT = 6'b00_0010;

    // Packed decode: valid, addr4, addr quad, data quad, dtr, read, dummy[4:0]
    function [10:0] decode;
        input [7:0] op;
        begin
            case (op)
                `OP_READ3: decode = {6'b10_0001, 5'h00};
                `OP_READ4: decode = {6'b11_0001, 5'h00};
                `OP_FAST3: decode = {6'b10_0001, `DUMMY_FAST};
                `OP_FAST4: decode = {6'b11_0001, `DUMMY_FAST};
                `OP_QOUT3: decode = {6'b10_0101, `DUMMY_QOUT};
                `OP_QOUT4: decode = {6'b11_0101, `DUMMY_QOUT};
                `OP_QIO3: decode = {6'b10_1101, `DUMMY_QIO};
                `OP_QIO4: decode = {6'b11_1101, `DUMMY_QIO};
                `OP_QDTR3: decode = {6'b10_1101, 5'h00} | {6'b00_0010, `DUMMY_QDTR};
                `OP_QDTR4: decode = {6'b11_1101, 5'h00} | {6'b00_0010, `DUMMY_QDTR};
                `OP_PP3: decode = {6'b10_0000, 5'h00};
                `OP_PP4: decode = {6'b11_0000, 5'h00};
                `OP_QPP3: decode = {6'b10_0100, 5'h00};
                `OP_QPP4: decode = {6'b11_0100, 5'h00};
                `OP_XQPP3: decode = {6'b10_1100, 5'h00};
                `OP_XQPP4: decode = {6'b11_1100, 5'h00};
                default: decode = 11'h000;
            endcase
        end
    endfunction

    // Beats needed for a bit count on one or four lines
    function [5:0] beats;
        input [5:0] bits;
        input quad;
        begin
            beats = quad ? {2'b00, bits[5:2]} : bits;
        end
    endfunction

    wire [5:0] pin_s;
    wire hw_hold;
    wire sclk_s;
    wire cs_n_s;
    wire [3:0] io_s;
    reg sclk_prev_q;
    reg cs_prev_q;
    reg [2:0] state_q;
    reg [5:0] cnt_q;
    reg [31:0] shift_q;
    reg arm_q;
    reg addr4_q;
    reg aq_q;
    reg dq_q;
    reg rd_q;
    reg [4:0] dummy_q;
    reg [7:0] out_q;
    reg [2:0] ocnt_q;

    flash_pin_sync #(
        .WIDTH(6),
        .INIT(SYNC_INIT)
    ) u_pin_sync (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_d({i_io, i_cs_n, i_sclk}),
        .o_q(pin_s)
    );

    flash_reset_pulse_filter u_reset_filter (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_hw_reset_n(i_hw_reset_n),
        .o_hold(hw_hold)
    );

    assign sclk_s = pin_s[0];
    assign cs_n_s = pin_s[1];
    assign io_s = pin_s[5:2];

    // Edges found by the core clock; idle level of SCLK does not matter
    wire sclk_rise = sclk_s & ~sclk_prev_q;
    wire sclk_fall = ~sclk_s & sclk_prev_q;
    wire cs_fall = ~cs_n_s & cs_prev_q;

    // Lane width of the current input phase
    wire wide = (state_q == ST_OPC) ? o_quad_command_mode : ((state_q == ST_ADDR) ? aq_q : dq_q);
    wire [31:0] in_d = wide ? {shift_q[27:0], io_s} : {shift_q[30:0], io_s[0]};
    wire [31:0] addr_d = addr4_q ? in_d : {8'h00, in_d[23:0]};
    wire [7:0] op_d = in_d[7:0];
    wire [10:0] dec = decode(op_d);
    wire dec_aq = dec[8] | o_quad_command_mode;
    wire dec_dq = dec[7] | o_quad_command_mode;
    // Address taken on both edges in DTR
    wire addr_samp = (o_dtr_active & cnt_q[0]) ? sclk_fall : sclk_rise;
    // Output shifts on falling edge, also rising in DTR
    wire out_edge = sclk_fall | (sclk_rise & o_dtr_active);
    wire quad_lines = o_quad_command_mode | ((state_q == ST_ADDR) & aq_q)
        | (((state_q == ST_DUMMY) | (state_q == ST_DIN) | (state_q == ST_DOUT)) & dq_q);

    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sclk_prev_q <= 1'b0;
            cs_prev_q <= 1'b1;
            state_q <= ST_IDLE;
            cnt_q <= 6'h00;
            shift_q <= 32'h0000_0000;
            arm_q <= 1'b0;
            addr4_q <= 1'b0;
            aq_q <= 1'b0;
            dq_q <= 1'b0;
            rd_q <= 1'b0;
            dummy_q <= 5'h00;
            out_q <= 8'h00;
            ocnt_q <= 3'h0;
            o_io <= 4'h0;
            o_io_oe_n <= 4'hF;
            o_cmd <= 8'h00;
            o_cmd_valid <= 1'b0;
            o_addr <= 32'h0000_0000;
            o_addr_valid <= 1'b0;
            o_page_index <= 19'h0_0000;
            o_sector_index <= 15'h0000;
            o_block32_index <= 12'h000;
            o_block64_index <= 11'h000;
            o_wr_data <= 8'h00;
            o_wr_valid <= 1'b0;
            o_rd_req <= 1'b0;
            o_frame_end <= 1'b0;
            o_quad_command_mode <= 1'b0;
            o_dtr_active <= 1'b0;
            o_write_protect <= 1'b0;
            o_reset_event <= 1'b0;
        end else begin
            sclk_prev_q <= sclk_s;
            cs_prev_q <= cs_n_s;
            o_cmd_valid <= 1'b0;
            o_addr_valid <= 1'b0;
            o_wr_valid <= 1'b0;
            o_rd_req <= 1'b0;
            o_frame_end <= 1'b0;
            o_reset_event <= 1'b0;
            // WP sampled only while IO2 is not carrying data
            if (!quad_lines) begin
                o_write_protect <= ~io_s[2];
            end
            if (hw_hold) begin
                // Pin reset overrides any state; volatile bits to power-on values
                state_q <= ST_IGNORE;
                o_quad_command_mode <= 1'b0;
                o_dtr_active <= 1'b0;
                arm_q <= 1'b0;
                ocnt_q <= 3'h0;
                o_io <= 4'h0;
                o_io_oe_n <= 4'hF;
                o_write_protect <= 1'b0;
                o_reset_event <= 1'b1;
            end else if (cs_n_s) begin
                // Frame over: drop partial frame, release lines
                o_frame_end <= (state_q != ST_IDLE);
                state_q <= ST_IDLE;
                o_io_oe_n <= 4'hF;
                o_io <= 4'h0;
                o_dtr_active <= 1'b0;
                ocnt_q <= 3'h0;
            end else if (cs_fall && state_q == ST_IDLE) begin
                state_q <= ST_OPC;
                shift_q <= 32'h0000_0000;
                cnt_q <= beats(6'd8, o_quad_command_mode);
            end else begin
                case (state_q)
                    ST_OPC: begin
                        if (sclk_rise) begin
                            shift_q <= in_d;
                            cnt_q <= cnt_q - 6'h01;
                            if (cnt_q == 6'h01) begin
                                o_cmd <= op_d;
                                o_cmd_valid <= 1'b1;
                                arm_q <= (op_d == `OP_RESET_ARM);
                                state_q <= ST_IGNORE;
                                if (op_d == `OP_QCMD_ENTER) begin
                                    o_quad_command_mode <= 1'b1;
                                end else if (op_d == `OP_QCMD_EXIT) begin
                                    o_quad_command_mode <= 1'b0;
                                end else if (op_d == `OP_RESET_GO && arm_q) begin
                                    o_quad_command_mode <= 1'b0;
                                    o_write_protect <= 1'b0;
                                    o_reset_event <= 1'b1;
                                end else if (dec[10]) begin
                                    state_q <= ST_ADDR;
                                    addr4_q <= dec[9];
                                    aq_q <= dec_aq;
                                    dq_q <= dec_dq;
                                    o_dtr_active <= dec[6];
                                    rd_q <= dec[5];
                                    dummy_q <= dec[4:0];
                                    cnt_q <= beats(dec[9] ? 6'd32 : 6'd24, dec_aq);
                                end
                            end
                        end
                    end
                    ST_ADDR: begin
                        if (addr_samp) begin
                            shift_q <= in_d;
                            cnt_q <= cnt_q - 6'h01;
                            if (cnt_q == 6'h01) begin
                                o_addr <= addr_d;
                                o_addr_valid <= 1'b1;
                                o_page_index <= addr_d[`ADDR_MSB:`PAGE_SHIFT];
                                o_sector_index <= addr_d[`ADDR_MSB:`SECTOR_SHIFT];
                                o_block32_index <= addr_d[`ADDR_MSB:`BLOCK32_SHIFT];
                                o_block64_index <= addr_d[`ADDR_MSB:`BLOCK64_SHIFT];
                                if (dummy_q != 5'h00) begin
                                    state_q <= ST_DUMMY;
                                    cnt_q <= {1'b0, dummy_q};
                                end else if (rd_q) begin
                                    state_q <= ST_DOUT;
                                    o_rd_req <= 1'b1;
                                end else begin
                                    state_q <= ST_DIN;
                                    cnt_q <= beats(6'd8, dq_q);
                                end
                            end
                        end
                    end
                    ST_DUMMY: begin
                        if (sclk_rise) begin
                            cnt_q <= cnt_q - 6'h01;
                            if (cnt_q == 6'h01) begin
                                state_q <= ST_DOUT;
                                o_rd_req <= 1'b1;
                            end
                        end
                    end
                    ST_DIN: begin
                        if (sclk_rise) begin
                            shift_q <= in_d;
                            cnt_q <= cnt_q - 6'h01;
                            if (cnt_q == 6'h01) begin
                                o_wr_data <= in_d[7:0];
                                o_wr_valid <= 1'b1;
                                cnt_q <= beats(6'd8, dq_q);
                            end
                        end
                    end
                    ST_DOUT: begin
                        if (out_edge) begin
                            if (ocnt_q == 3'h0) begin
                                if (dq_q) begin
                                    o_io <= i_rd_data[7:4];
                                    out_q <= {i_rd_data[3:0], 4'h0};
                                    ocnt_q <= 3'h1;
                                    o_io_oe_n <= 4'h0;
                                end else begin
                                    o_io <= {2'b00, i_rd_data[7], 1'b0};
                                    out_q <= {i_rd_data[6:0], 1'b0};
                                    ocnt_q <= 3'h7;
                                    o_io_oe_n <= 4'hD;
                                end
                            end else begin
                                if (dq_q) begin
                                    o_io <= out_q[7:4];
                                    out_q <= {out_q[3:0], 4'h0};
                                end else begin
                                    o_io <= {2'b00, out_q[7], 1'b0};
                                    out_q <= {out_q[6:0], 1'b0};
                                end
                                ocnt_q <= ocnt_q - 3'h1;
                                if (ocnt_q == 3'h1) begin
                                    o_rd_req <= 1'b1;
                                end
                            end
                        end
                    end
                    ST_IGNORE: begin
                        o_io_oe_n <= 4'hF;
                    end
                    ST_IDLE: begin
                        o_io_oe_n <= 4'hF;
                    end
                    default: begin
                        state_q <= ST_IGNORE;
                    end
                endcase
            end
        end
    end
endmodule // serial_flash_bus_front_end

// ==== sim/serial_flash_bus_front_end_monitor.sv ====
// Concurrent checks on the serial flash bus front end ports.
// Assumes one core clock domain; all pins are asynchronous to it.
module serial_flash_bus_front_end_monitor (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // Pins
    input wire logic i_cs_n,
    input wire logic i_hw_reset_n,
    input wire logic [3:0] o_io_oe_n,
    // Decoded frame
    input wire logic [7:0] o_cmd,
    input wire logic [31:0] o_addr,
    input wire logic o_addr_valid,
    input wire logic [18:0] o_page_index,
    input wire logic [14:0] o_sector_index,
    input wire logic [11:0] o_block32_index,
    input wire logic [10:0] o_block64_index,
    // Status
    input wire logic o_frame_end,
    input wire logic o_quad_command_mode,
    input wire logic o_dtr_active,
    input wire logic o_reset_event
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] low_cnt_q;
    default clocking @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);
    // Cycles the reset pin has been low, saturating
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n)
            low_cnt_q <= 8'h00;
        else if (i_hw_reset_n)
            low_cnt_q <= 8'h00;
        else if (low_cnt_q != 8'hFF)
            low_cnt_q <= low_cnt_q + 8'h01;
    end
    sequence cs_idle;
        i_cs_n [*5];
    endsequence
    sequence enter_seen;
        ##[0:3] (o_cmd == 8'h38);
    endsequence
    sequence leave_seen;
        ##[0:3] (o_cmd == 8'hFF || o_cmd == 8'h99 || o_reset_event);
    endsequence
    AST_OE_IDLE: assert property (cs_idle |-> o_io_oe_n == 4'hF)
        else $error("data lines driven while deselected");
    AST_OE_SHAPE: assert property (o_io_oe_n inside {4'hF, 4'hD, 4'h0})
        else $error("illegal data line direction");
    AST_INDEX: assert property (o_addr_valid |-> o_page_index == o_addr[26:8]
        && o_sector_index == o_addr[26:12] && o_block32_index == o_addr[26:15]
        && o_block64_index == o_addr[26:16]) else $error("array index mismatch");
    AST_QMODE_ENTER: assert property ($rose(o_quad_command_mode) |-> enter_seen)
        else $error("quad command mode entered without enter opcode");
    AST_QMODE_LEAVE: assert property ($fell(o_quad_command_mode) |-> leave_seen)
        else $error("quad command mode left without cause");
    AST_DTR_OPCODE: assert property ($rose(o_dtr_active) |-> ##[0:3] (o_cmd == 8'hED || o_cmd == 8'hEE))
        else $error("double rate without its opcode");
    AST_FRAME_END: assert property (o_frame_end |-> i_cs_n ##1 !o_frame_end)
        else $error("frame end without chip select high");
    AST_PIN_RESET: assert property (low_cnt_q > 8'h6E |-> o_reset_event && !o_quad_command_mode
        && o_io_oe_n == 4'hF) else $error("pin reset not taken");
    AST_SHORT_PULSE: assert property ($rose(i_hw_reset_n) && low_cnt_q < 8'h50 |-> !o_reset_event)
        else $error("short reset pulse taken");
endmodule // serial_flash_bus_front_end_monitor

bind serial_flash_bus_front_end serial_flash_bus_front_end_monitor i_serial_flash_bus_front_end_monitor (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_cs_n(i_cs_n), .i_hw_reset_n(i_hw_reset_n),
    .o_io_oe_n(o_io_oe_n), .o_cmd(o_cmd), .o_addr(o_addr), .o_addr_valid(o_addr_valid),
    .o_page_index(o_page_index), .o_sector_index(o_sector_index), .o_block32_index(o_block32_index),
    .o_block64_index(o_block64_index), .o_frame_end(o_frame_end),
    .o_quad_command_mode(o_quad_command_mode), .o_dtr_active(o_dtr_active), .o_reset_event(o_reset_event));

// ==== sim/flash_host_model.sv ====
// Host controller model driving serial clock, chip select and data lines.
// Assumes the bench resolves the shared data lines from both enables.
module flash_host_model (
    // Clock
    input wire logic i_core_clk,
    // Bus toward the device
    input wire logic [3:0] i_io,
    output logic o_sclk,
    output logic o_cs_n,
    output logic [3:0] o_out,
    output logic [3:0] o_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    logic cpol = 1'b0;
    logic wp_level = 1'b1;
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_out = 4'hC;
        o_oe = 4'hC;
    end
    // Half of a 160 ns link clock period
    task automatic half();
        repeat (8) @(posedge i_core_clk);
        #1;
    endtask
    task automatic idle(input logic pol);
        cpol = pol;
        o_sclk = pol;
        half();
    endtask
    task automatic select();
        o_cs_n = 1'b0;
        half();
    endtask
    task automatic deselect();
        o_sclk = cpol;
        half();
        o_cs_n = 1'b1;
        o_out = {1'b1, wp_level, 2'b00};
        o_oe = 4'hC;
        half();
        half();
    endtask
    // Data set at the fall, device output taken just before the rise
    task automatic beat(input logic [3:0] v, input logic [3:0] oe, output logic [3:0] got);
        o_out = v;
        o_oe = oe;
        o_sclk = 1'b0;
        half();
        got = i_io;
        o_sclk = 1'b1;
        half();
    endtask
    task automatic xfer(input logic [7:0] b, input logic quad, input logic drive, output logic [7:0] got);
        logic [3:0] g;
        if (quad) begin
            beat(b[7:4], {4{drive}}, g);
            got[7:4] = g;
            beat(b[3:0], {4{drive}}, g);
            got[3:0] = g;
        end else begin
            for (int i = 7; i >= 0; i--) begin
                beat({1'b1, wp_level, 1'b0, b[i]}, 4'hD, g);
                got[i] = g[1];
            end
        end
    endtask
endmodule // flash_host_model

// ==== sim/serial_flash_bus_front_end_tb.sv ====
// Self-checking bench for the serial flash bus front end.
// Assumes the host model drives the pins and the bound checker watches the ports.
`define CHECK_EQ(got, exp) begin total_checks++; if ((got) !== (exp)) begin miscompares++; \
    $display("ERROR t=%0t got %0h expected %0h", $time, (got), (exp)); end end
module serial_flash_bus_front_end_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_core_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_hw_reset_n = 1'b1;
    logic [7:0] i_rd_data = 8'h00;
    logic float_q = 1'b0;
    logic rst_seen = 1'b0;
    logic [7:0] wr_byte = 8'h00;
    logic [7:0] ops [10] = '{8'h6B, 8'h6C, 8'hEB, 8'hEC, 8'h32, 8'h34, 8'hC2, 8'h3E, 8'hED, 8'hEE};
    int miscompares = 0;
    int total_checks = 0;
    int rd_reqs = 0;
    wire sclk, cs_n, cmd_valid, addr_valid, wr_valid, qmode, dtr, wp, rst_evt, rd_req;
    wire [3:0] io, o_io, oe_n, h_out, h_oe;
    wire [7:0] cmd, wr_data;
    wire [31:0] addr;
    wire [18:0] page;
    wire [14:0] sector;
    wire [11:0] blk32;
    wire [10:0] blk64;
    // Released lines show a pattern that changes every cycle
    assign io = (~oe_n & o_io) | (oe_n & h_oe & h_out) | (oe_n & ~h_oe & {4{float_q}});
    serial_flash_bus_front_end i_serial_flash_bus_front_end (
        .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_sclk(sclk), .i_cs_n(cs_n),
        .i_hw_reset_n(i_hw_reset_n), .i_io(io), .o_io(o_io), .o_io_oe_n(oe_n), .o_cmd(cmd),
        .o_cmd_valid(cmd_valid), .o_addr(addr), .o_addr_valid(addr_valid), .o_page_index(page),
        .o_sector_index(sector), .o_block32_index(blk32), .o_block64_index(blk64),
        .o_wr_data(wr_data), .o_wr_valid(wr_valid), .o_rd_req(rd_req), .i_rd_data(i_rd_data),
        .o_frame_end(), .o_quad_command_mode(qmode), .o_dtr_active(dtr),
        .o_write_protect(wp), .o_reset_event(rst_evt));
    flash_host_model i_flash_host_model (
        .i_core_clk(i_core_clk), .i_io(io), .o_sclk(sclk), .o_cs_n(cs_n), .o_out(h_out), .o_oe(h_oe));
    initial begin
        forever #5 i_core_clk = ~i_core_clk;
    end
    always @(posedge i_core_clk) begin
        float_q <= ~float_q;
        if (wr_valid === 1'b1)
            wr_byte = wr_data;
        if (rst_evt === 1'b1)
            rst_seen = 1'b1;
        if (rd_req === 1'b1)
            rd_reqs++;
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic tx(input logic [7:0] b, input logic q);
        logic [7:0] g;
        i_flash_host_model.xfer(b, q, 1'b1, g);
    endtask
    task automatic frame(input logic [7:0] op, input logic q);
        i_flash_host_model.select();
        tx(op, q);
        i_flash_host_model.deselect();
    endtask
    task automatic test_single_read();
        logic [7:0] got;
        i_rd_data = 8'hA5;
        i_flash_host_model.wp_level = 1'b0;
        i_flash_host_model.idle(1'b0);
        i_flash_host_model.select();
        tx(8'h03, 1'b0);
        tx(8'h12, 1'b0);
        tx(8'h34, 1'b0);
        tx(8'h56, 1'b0);
        i_flash_host_model.xfer(8'h00, 1'b0, 1'b1, got);
        `CHECK_EQ(got, 8'hA5)
        `CHECK_EQ(rd_reqs, 2)
        `CHECK_EQ(oe_n, 4'hD)
        `CHECK_EQ(cmd, 8'h03)
        `CHECK_EQ(addr, 32'h0012_3456)
        `CHECK_EQ(page, 19'h0_1234)
        `CHECK_EQ(sector, 15'h0123)
        `CHECK_EQ(blk32, 12'h024)
        `CHECK_EQ(blk64, 11'h012)
        i_flash_host_model.deselect();
        `CHECK_EQ(oe_n, 4'hF)
        `CHECK_EQ(wp, 1'b1)
        $display("test_single_read done");
    endtask
    task automatic test_quad_read();
        logic [7:0] got;
        i_rd_data = 8'h5A;
        i_flash_host_model.idle(1'b1);
        i_flash_host_model.select();
        tx(8'h6B, 1'b0);
        tx(8'h00, 1'b0);
        tx(8'h01, 1'b0);
        tx(8'h00, 1'b0);
        repeat (5) i_flash_host_model.xfer(8'h00, 1'b1, 1'b0, got);
        `CHECK_EQ(got, 8'h5A)
        `CHECK_EQ(oe_n, 4'h0)
        i_flash_host_model.deselect();
        `CHECK_EQ(addr, 32'h0000_0100)
        i_flash_host_model.idle(1'b0);
        $display("test_quad_read done");
    endtask
    task automatic test_quad_program();
        i_flash_host_model.wp_level = 1'b1;
        i_flash_host_model.select();
        tx(8'h32, 1'b0);
        tx(8'h00, 1'b0);
        tx(8'h02, 1'b0);
        tx(8'h00, 1'b0);
        tx(8'h33, 1'b1);
        `CHECK_EQ(wr_byte, 8'h33)
        `CHECK_EQ(wp, 1'b0)
        i_flash_host_model.deselect();
        `CHECK_EQ(wp, 1'b0)
        $display("test_quad_program done");
    endtask
    task automatic test_opcode_table();
        foreach (ops[k]) begin
            i_flash_host_model.select();
            tx(ops[k], 1'b0);
            `CHECK_EQ(cmd, ops[k])
            `CHECK_EQ(dtr, (k >= 8))
            i_flash_host_model.deselect();
            `CHECK_EQ(dtr, 1'b0)
        end
        $display("test_opcode_table done");
    endtask
    task automatic test_mode_switch();
        logic [3:0] g;
        i_flash_host_model.select();
        for (int n = 0; n < 4; n++)
            i_flash_host_model.beat({3'b110, (n > 1)}, 4'hD, g);
        i_flash_host_model.deselect();
        `CHECK_EQ(qmode, 1'b0)
        frame(8'h38, 1'b0);
        `CHECK_EQ(qmode, 1'b1)
        frame(8'h38, 1'b1);
        `CHECK_EQ(qmode, 1'b1)
        frame(8'hFF, 1'b1);
        `CHECK_EQ(qmode, 1'b0)
        frame(8'h38, 1'b0);
        rst_seen = 1'b0;
        frame(8'h66, 1'b1);
        frame(8'h99, 1'b1);
        `CHECK_EQ(qmode, 1'b0)
        `CHECK_EQ(rst_seen, 1'b1)
        rst_seen = 1'b0;
        frame(8'h99, 1'b0);
        `CHECK_EQ(rst_seen, 1'b0)
        $display("test_mode_switch done");
    endtask
    task automatic test_hw_reset();
        frame(8'h38, 1'b0);
        i_hw_reset_n = 1'b0;
        repeat (50) @(posedge i_core_clk);
        #1 i_hw_reset_n = 1'b1;
        repeat (4) @(posedge i_core_clk);
        `CHECK_EQ(qmode, 1'b1)
        i_flash_host_model.select();
        tx(8'h03, 1'b1);
        tx(8'h12, 1'b1);
        i_hw_reset_n = 1'b0;
        repeat (120) @(posedge i_core_clk);
        #1;
        `CHECK_EQ(rst_evt, 1'b1)
        `CHECK_EQ(qmode, 1'b0)
        `CHECK_EQ(oe_n, 4'hF)
        i_hw_reset_n = 1'b1;
        i_flash_host_model.deselect();
        frame(8'h38, 1'b0);
        `CHECK_EQ(qmode, 1'b1)
        $display("test_hw_reset done");
    endtask
    initial begin
        repeat (6) @(posedge i_core_clk);
        #1 i_rst_n = 1'b1;
        repeat (4) @(posedge i_core_clk);
        #1;
        test_single_read();
        test_quad_read();
        test_quad_program();
        test_opcode_table();
        test_mode_switch();
        test_hw_reset();
        complete_run();
    end
    initial begin
        repeat (40000) @(posedge i_core_clk);
        miscompares++;
        complete_run();
    end
endmodule // serial_flash_bus_front_end_tb
